/* ebr_pkg.sv */
package ebr_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses, bits 11:2 decoded)
    // ------------------------------------------------------------------
    localparam logic [11:0] ADDR_LE_REGION   = 12'h000;
    localparam logic [11:0] ADDR_MACHINE     = 12'h004;
    localparam logic [11:0] ADDR_STATUS      = 12'h008;
    localparam logic [11:0] ADDR_CNT_FETCH   = 12'h00C;
    localparam logic [11:0] ADDR_CNT_LOAD    = 12'h010;
    localparam logic [11:0] ADDR_CNT_STORE   = 12'h014;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int          MACH_IR_BIT      = 0;
    localparam int          MACH_DR_BIT      = 1;
    localparam int          STAT_FETCH_LE    = 0;
    localparam int          STAT_DATA_LE     = 1;
    localparam int          STAT_DATA_REV    = 2;
    localparam int          REGION_LSB       = 27;
    localparam int          CNT_W            = 16;
    localparam logic [31:0] RST_LE_REGION    = 32'h0000_0000;
    localparam logic        RST_RELOC        = 1'b0;
    localparam logic [31:0] RST_WORD         = 32'h0000_0000;
    localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;
    localparam logic        HRESP_OKAY       = 1'b0;

    // ------------------------------------------------------------------
    // Access sizes and bus phase
    // ------------------------------------------------------------------
    localparam logic [1:0]  SZ_BYTE          = 2'h0;
    localparam logic [1:0]  SZ_HALF          = 2'h1;
    localparam logic [1:0]  SZ_WORD          = 2'h2;

    typedef enum logic [0:0] {
        PH_IDLE  = 1'b0,
        PH_WRITE = 1'b1
    } ebr_phase_e;

    function automatic logic [2:0] size_bytes(input logic [1:0] sz);
        case (sz)
            SZ_BYTE: size_bytes = 3'h1;
            SZ_HALF: size_bytes = 3'h2;
            default: size_bytes = 3'h4;
        endcase
    endfunction

    function automatic logic [31:0] rev32(input logic [31:0] w);
        rev32 = {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction

    // Endian flag of one access: translation entry or region register
    function automatic logic pick_le(input logic reloc, input logic tlb_e,
                                     input logic [31:0] regions, input logic [31:0] addr);
        pick_le = reloc ? tlb_e : regions[addr[31:REGION_LSB]];
    endfunction

endpackage

`timescale 1ns/10ps

// ----------------------------------------------------------------------
// Byte lane steering between cache words and register value
// ----------------------------------------------------------------------
module ebr_lane_unit
(
    // Cache side, two consecutive words, byte at lowest address in [31:24]
    input  wire logic [31:0] ld_word0,
    input  wire logic [31:0] ld_word1,
    // Access description
    input  wire logic [1:0]  offset,
    input  wire logic [1:0]  size,
    input  wire logic        swap,
    input  wire logic [31:0] st_value,
    // Results
    output logic      [31:0] ld_value,
    output logic      [31:0] st_word0,
    output logic      [31:0] st_word1,
    output logic      [3:0]  st_be0,
    output logic      [3:0]  st_be1
);
    logic [7:0] img [0:7];
    logic [7:0] b   [0:3];
    logic [7:0] so  [0:7];
    logic [7:0] en;
    logic [2:0] n;
    logic [2:0] pos;
    logic [2:0] k;

    always_comb
    begin
        n   = ebr_pkg::size_bytes(size);
        pos = 3'h0;
        k   = 3'h0;
        for (int i = 0; i < 4; i++)
        begin
            img[i]     = ld_word0[8*(3-i) +: 8];
            img[i + 4] = ld_word1[8*(3-i) +: 8];
        end
        // Misaligned pieces are joined first, then reversed as one item
        for (int i = 0; i < 4; i++)
        begin
            pos  = 3'(offset) + 3'(i);
            b[i] = img[pos];
        end
        case (n)
            3'h1:    ld_value = {24'h00_0000, b[0]};
            3'h2:    ld_value = swap ? {16'h0000, b[1], b[0]} : {16'h0000, b[0], b[1]};
            default: ld_value = swap ? {b[3], b[2], b[1], b[0]} : {b[0], b[1], b[2], b[3]};
        endcase
        for (int i = 0; i < 8; i++)
        begin
            so[i] = 8'h00;
            en[i] = 1'b0;
        end
        for (int i = 0; i < 4; i++)
        begin
            if (3'(i) < n)
            begin
                k       = swap ? 3'(i) : (n - 3'h1 - 3'(i));
                pos     = 3'(offset) + 3'(i);
                so[pos] = st_value[8*k +: 8];
                en[pos] = 1'b1;
            end
        end
        st_word0 = {so[0], so[1], so[2], so[3]};
        st_word1 = {so[4], so[5], so[6], so[7]};
        st_be0   = {en[0], en[1], en[2], en[3]};
        st_be1   = {en[4], en[5], en[6], en[7]};
    end

endmodule

/* ebr_top.sv */

`timescale 1ns/10ps

module ebr_top
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // AHB-Lite register slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Instruction fill from memory
    input  wire logic        fetch_req,
    input  wire logic [31:0] fetch_addr,
    input  wire logic        fetch_tlb_le,
    input  wire logic [31:0] fetch_mem_word,
    output logic             fill_valid,
    output logic      [31:0] fill_word,
    output logic             fill_le,
    // Load from data cache to register file
    input  wire logic        ld_req,
    input  wire logic [31:0] ld_addr,
    input  wire logic [1:0]  ld_size,
    input  wire logic        ld_byte_rev,
    input  wire logic        ld_tlb_le,
    input  wire logic [31:0] ld_cache_word0,
    input  wire logic [31:0] ld_cache_word1,
    output logic             ld_valid,
    output logic      [31:0] ld_result,
    output logic             ld_le,
    output logic             ld_misaligned,
    // Store from register file to data cache
    input  wire logic        st_req,
    input  wire logic [31:0] st_addr,
    input  wire logic [1:0]  st_size,
    input  wire logic        st_byte_rev,
    input  wire logic        st_tlb_le,
    input  wire logic [31:0] st_reg_value,
    output logic             st_valid,
    output logic      [31:0] st_addr_out,
    output logic      [31:0] st_word0,
    output logic      [31:0] st_word1,
    output logic      [3:0]  st_be0,
    output logic      [3:0]  st_be1,
    output logic             st_spans,
    output logic             st_misaligned
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [31:0]                     le_regions;
        logic                            instr_relocate_en;
        logic                            data_relocate_en;
        ebr_pkg::ebr_phase_e             phase;
        logic [11:0]                     wr_addr;
        logic [31:0]                     hrdata;
        logic                            hreadyout;
        logic                            hresp;
        logic                            last_fetch_le;
        logic                            last_data_le;
        logic                            last_data_rev;
        logic [ebr_pkg::CNT_W-1:0]       cnt_fetch;
        logic [ebr_pkg::CNT_W-1:0]       cnt_load;
        logic [ebr_pkg::CNT_W-1:0]       cnt_store;
        logic                            fill_valid;
        logic [31:0]                     fill_word;
        logic                            fill_le;
        logic                            ld_valid;
        logic [31:0]                     ld_result;
        logic                            ld_le;
        logic                            ld_misaligned;
        logic                            st_valid;
        logic [31:0]                     st_addr;
        logic [31:0]                     st_word0;
        logic [31:0]                     st_word1;
        logic [3:0]                      st_be0;
        logic [3:0]                      st_be1;
        logic                            st_spans;
        logic                            st_misaligned;
    } ebr_state_s;

    ebr_state_s st_ff;
    ebr_state_s nxt_st;

    // ------------------------------------------------------------------
    // Endian selection per access
    // ------------------------------------------------------------------
    logic        fetch_le;
    logic        ld_region_le;
    logic        st_region_le;
    logic        ld_swap;
    logic        st_swap;
    logic [31:0] ld_value;
    logic [31:0] st_w0;
    logic [31:0] st_w1;
    logic [3:0]  st_b0;
    logic [3:0]  st_b1;

    // Translation entry wins while relocation is on, else region register
    assign fetch_le     = ebr_pkg::pick_le(st_ff.instr_relocate_en, fetch_tlb_le,
                                           st_ff.le_regions, fetch_addr);
    assign ld_region_le = ebr_pkg::pick_le(st_ff.data_relocate_en, ld_tlb_le,
                                           st_ff.le_regions, ld_addr);
    assign st_region_le = ebr_pkg::pick_le(st_ff.data_relocate_en, st_tlb_le,
                                           st_ff.le_regions, st_addr);

    // Both mechanisms together cancel out
    assign ld_swap = ld_region_le ^ ld_byte_rev;
    assign st_swap = st_region_le ^ st_byte_rev;

    // ------------------------------------------------------------------
    // Lane steering, shared by loads and stores
    // ------------------------------------------------------------------
    // Cache words enter untouched; the swap sits on the register side
    ebr_lane_unit u_lanes
    (
        .ld_word0 (ld_cache_word0),
        .ld_word1 (ld_cache_word1),
        .offset   (ld_req ? ld_addr[1:0] : st_addr[1:0]),
        .size     (ld_req ? ld_size : st_size),
        .swap     (ld_req ? ld_swap : st_swap),
        .st_value (st_reg_value),
        .ld_value (ld_value),
        .st_word0 (st_w0),
        .st_word1 (st_w1),
        .st_be0   (st_b0),
        .st_be1   (st_b1)
    );

    // ------------------------------------------------------------------
    // Misalignment, blind to the endian flag
    // ------------------------------------------------------------------
    function automatic logic is_misaligned(input logic [1:0] sz, input logic [1:0] off);
        case (sz)
            ebr_pkg::SZ_BYTE: is_misaligned = 1'b0;
            ebr_pkg::SZ_HALF: is_misaligned = off[0];
            default:          is_misaligned = (off != 2'h0);
        endcase
    endfunction

    function automatic logic spans_words(input logic [1:0] sz, input logic [1:0] off);
        logic [3:0] last;
        last        = 4'(off) + 4'(ebr_pkg::size_bytes(sz));
        spans_words = (last > 4'h4);
    endfunction

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    logic        addr_phase;
    logic [11:0] rd_addr;

    assign addr_phase = hsel && hready && (htrans == ebr_pkg::HTRANS_NONSEQ);
    assign rd_addr    = haddr[11:0];

    always_comb
    begin
        nxt_st           = st_ff;
        nxt_st.hreadyout = 1'b1;
        nxt_st.hresp     = ebr_pkg::HRESP_OKAY;

        // Register write lands in its data phase
        case (st_ff.phase)
            ebr_pkg::PH_WRITE:
            begin
                case (st_ff.wr_addr)
                    ebr_pkg::ADDR_LE_REGION: nxt_st.le_regions = hwdata;
                    ebr_pkg::ADDR_MACHINE:
                    begin
                        nxt_st.instr_relocate_en = hwdata[ebr_pkg::MACH_IR_BIT];
                        nxt_st.data_relocate_en  = hwdata[ebr_pkg::MACH_DR_BIT];
                    end
                    default:
                    begin
                        nxt_st.le_regions = st_ff.le_regions;
                    end
                endcase
            end
            ebr_pkg::PH_IDLE:
            begin
                nxt_st.le_regions = st_ff.le_regions;
            end
            default:
            begin
                nxt_st.phase = ebr_pkg::PH_IDLE;
            end
        endcase

        // Fill path: reversal before the cache, none after it
        nxt_st.fill_valid = fetch_req;
        if (fetch_req)
        begin
            nxt_st.fill_word     = fetch_le ? ebr_pkg::rev32(fetch_mem_word) : fetch_mem_word;
            nxt_st.fill_le       = fetch_le;
            nxt_st.last_fetch_le = fetch_le;
            if (fetch_le)
            begin
                nxt_st.cnt_fetch = st_ff.cnt_fetch + 1'b1;
            end
        end

        // Load path; a store is not taken in a cycle where a load owns the lane unit
        nxt_st.ld_valid = ld_req;
        nxt_st.st_valid = st_req && !ld_req;
        if (ld_req)
        begin
            nxt_st.ld_result     = ld_value;
            nxt_st.ld_le         = ld_region_le;
            nxt_st.ld_misaligned = is_misaligned(ld_size, ld_addr[1:0]);
            nxt_st.last_data_le  = ld_region_le;
            nxt_st.last_data_rev = ld_byte_rev;
            if (ld_region_le)
            begin
                nxt_st.cnt_load = st_ff.cnt_load + 1'b1;
            end
        end
        else if (st_req)
        begin
            nxt_st.st_addr       = st_addr;
            nxt_st.st_word0      = st_w0;
            nxt_st.st_word1      = st_w1;
            nxt_st.st_be0        = st_b0;
            nxt_st.st_be1        = st_b1;
            nxt_st.st_spans      = spans_words(st_size, st_addr[1:0]);
            nxt_st.st_misaligned = is_misaligned(st_size, st_addr[1:0]);
            nxt_st.last_data_le  = st_region_le;
            nxt_st.last_data_rev = st_byte_rev;
            if (st_region_le)
            begin
                nxt_st.cnt_store = st_ff.cnt_store + 1'b1;
            end
        end

        // Counter clear by write; an event in the same cycle still counts
        if (st_ff.phase == ebr_pkg::PH_WRITE)
        begin
            if (st_ff.wr_addr == ebr_pkg::ADDR_CNT_FETCH)
            begin
                nxt_st.cnt_fetch = (fetch_req && fetch_le) ? ebr_pkg::CNT_W'(1) : '0;
            end
            if (st_ff.wr_addr == ebr_pkg::ADDR_CNT_LOAD)
            begin
                nxt_st.cnt_load = (ld_req && ld_region_le) ? ebr_pkg::CNT_W'(1) : '0;
            end
            if (st_ff.wr_addr == ebr_pkg::ADDR_CNT_STORE)
            begin
                nxt_st.cnt_store = (st_req && !ld_req && st_region_le) ? ebr_pkg::CNT_W'(1) : '0;
            end
        end

        // Address phase: read data is built from post-write state so a read
        // right behind a write sees the new value
        nxt_st.phase = ebr_pkg::PH_IDLE;
        if (addr_phase)
        begin
            if (hwrite)
            begin
                nxt_st.phase   = ebr_pkg::PH_WRITE;
                nxt_st.wr_addr = {rd_addr[11:2], 2'h0};
            end
            else
            begin
                case ({rd_addr[11:2], 2'h0})
                    ebr_pkg::ADDR_LE_REGION: nxt_st.hrdata = nxt_st.le_regions;
                    ebr_pkg::ADDR_MACHINE:   nxt_st.hrdata = {30'h0000_0000,
                                                              nxt_st.data_relocate_en,
                                                              nxt_st.instr_relocate_en};
                    ebr_pkg::ADDR_STATUS:    nxt_st.hrdata = {29'h0000_0000,
                                                              nxt_st.last_data_rev,
                                                              nxt_st.last_data_le,
                                                              nxt_st.last_fetch_le};
                    ebr_pkg::ADDR_CNT_FETCH: nxt_st.hrdata = {16'h0000, nxt_st.cnt_fetch};
                    ebr_pkg::ADDR_CNT_LOAD:  nxt_st.hrdata = {16'h0000, nxt_st.cnt_load};
                    ebr_pkg::ADDR_CNT_STORE: nxt_st.hrdata = {16'h0000, nxt_st.cnt_store};
                    default:                 nxt_st.hrdata = ebr_pkg::RST_WORD;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            st_ff                   <= '0;
            st_ff.le_regions        <= ebr_pkg::RST_LE_REGION;
            st_ff.instr_relocate_en <= ebr_pkg::RST_RELOC;
            st_ff.data_relocate_en  <= ebr_pkg::RST_RELOC;
            st_ff.phase             <= ebr_pkg::PH_IDLE;
            st_ff.hreadyout         <= 1'b1;
            st_ff.hresp             <= ebr_pkg::HRESP_OKAY;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign hrdata        = st_ff.hrdata;
    assign hreadyout     = st_ff.hreadyout;
    assign hresp         = st_ff.hresp;
    assign fill_valid    = st_ff.fill_valid;
    assign fill_word     = st_ff.fill_word;
    assign fill_le       = st_ff.fill_le;
    assign ld_valid      = st_ff.ld_valid;
    assign ld_result     = st_ff.ld_result;
    assign ld_le         = st_ff.ld_le;
    assign ld_misaligned = st_ff.ld_misaligned;
    assign st_valid      = st_ff.st_valid;
    assign st_addr_out   = st_ff.st_addr;
    assign st_word0      = st_ff.st_word0;
    assign st_word1      = st_ff.st_word1;
    assign st_be0        = st_ff.st_be0;
    assign st_be1        = st_ff.st_be1;
    assign st_spans      = st_ff.st_spans;
    assign st_misaligned = st_ff.st_misaligned;

endmodule

/* ebr_mem_model.sv */
`timescale 1ns/10ps

// ----------------------------------------------------------------
// Memory behind the caches, byte k holds 8'h10 + (k mod 64)
// ----------------------------------------------------------------
module ebr_mem_model
(
    // Addresses from the core
    input  wire logic [31:0] fetch_addr,
    input  wire logic [31:0] ld_addr,
    // Words in address order, lowest byte on [31:24]
    output logic      [31:0] fetch_mem_word,
    output logic      [31:0] ld_cache_word0,
    output logic      [31:0] ld_cache_word1
);
    function automatic logic [31:0] wd(input logic [31:0] a);
        logic [5:0] b;
        b  = {a[5:2], 2'h0};
        wd = {8'h10 + {2'h0, b}, 8'h11 + {2'h0, b}, 8'h12 + {2'h0, b}, 8'h13 + {2'h0, b}};
    endfunction

    // Data reaches the cache side in memory order, never swapped
    assign fetch_mem_word = wd(fetch_addr);
    assign ld_cache_word0 = wd(ld_addr);
    assign ld_cache_word1 = wd(ld_addr + 32'h0000_0004);
endmodule

/* ebr_top_properties.sv */
`timescale 1ns/10ps

module ebr_top_properties
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // Fetch and load/store
    input wire logic        fetch_req,
    input wire logic [31:0] fetch_mem_word,
    input wire logic        fill_valid,
    input wire logic [31:0] fill_word,
    input wire logic        fill_le,
    input wire logic        ld_req,
    input wire logic [31:0] ld_addr,
    input wire logic [1:0]  ld_size,
    input wire logic        ld_byte_rev,
    input wire logic [31:0] ld_cache_word0,
    input wire logic        ld_valid,
    input wire logic [31:0] ld_result,
    input wire logic        ld_le,
    input wire logic        ld_misaligned,
    input wire logic        st_req,
    input wire logic [31:0] st_addr,
    input wire logic        st_valid,
    input wire logic [31:0] st_addr_out,
    input wire logic        st_spans
);
    logic [31:0] pf, pw, pa;
    logic [1:0]  ps;
    logic        pr;

    // Request-side values one cycle back, for the answer cycle
    always_ff @(posedge clk)
    begin
        pf <= fetch_mem_word;
        pw <= ld_cache_word0;
        pa <= ld_addr;
        ps <= ld_size;
        pr <= ld_byte_rev;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_fill; fetch_req |=> fill_valid && fill_word == (fill_le ? {pf[7:0], pf[15:8], pf[23:16], pf[31:24]} : pf); endproperty
    a_fill: assert property (p_fill) else $error("fill word wrong");
    property p_fill_only; !fetch_req |=> !fill_valid; endproperty
    a_fill_only: assert property (p_fill_only) else $error("fill without fetch");
    property p_ldv; ld_req |=> ld_valid; endproperty
    a_ldv: assert property (p_ldv) else $error("load not answered");
    property p_stv; st_req && !ld_req |=> st_valid && st_addr_out == $past(st_addr); endproperty
    a_stv: assert property (p_stv) else $error("store address changed");
    property p_byte; ld_req && ld_size == ebr_pkg::SZ_BYTE && ld_addr[1:0] == 2'h0 |=> ld_result == {24'h0, pw[31:24]}; endproperty
    a_byte: assert property (p_byte) else $error("byte load reordered");
    property p_half; ld_req && ld_size == ebr_pkg::SZ_HALF && ld_addr[1:0] == 2'h0
        |=> ld_result == ((ld_le ^ pr) ? {16'h0, pw[23:16], pw[31:24]} : {16'h0, pw[31:16]}); endproperty
    a_half: assert property (p_half) else $error("halfword load wrong");
    property p_word; ld_req && ld_size == ebr_pkg::SZ_WORD && ld_addr[1:0] == 2'h0
        |=> ld_result == ((ld_le ^ pr) ? {pw[7:0], pw[15:8], pw[23:16], pw[31:24]} : pw); endproperty
    a_word: assert property (p_word) else $error("word load wrong");
    property p_mis; ld_req |=> ld_misaligned == (ps == ebr_pkg::SZ_HALF ? pa[0] : ps != ebr_pkg::SZ_BYTE && pa[1:0] != 2'h0); endproperty
    a_mis: assert property (p_mis) else $error("misaligned flag wrong");

    c_fetch_le: cover property (fetch_req ##1 fill_le);
    c_ld_span: cover property (ld_req && ld_addr[1:0] == 2'h3);
    c_st_span: cover property (st_req ##1 st_spans);
endmodule

bind ebr_top ebr_top_properties u_props (.*);

/* test_endian_byte_reorder.sv */
`timescale 1ns/10ps

module test_endian_byte_reorder;
    logic        clk, rst_n, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0]  htrans, ld_size, st_size;
    logic [2:0]  hsize;
    logic        fetch_req, fetch_tlb_le, fill_valid, fill_le;
    logic [31:0] fetch_addr, fetch_mem_word, fill_word;
    logic        ld_req, ld_byte_rev, ld_tlb_le, ld_valid, ld_le, ld_misaligned;
    logic [31:0] ld_addr, ld_cache_word0, ld_cache_word1, ld_result;
    logic        st_req, st_byte_rev, st_tlb_le, st_valid, st_spans, st_misaligned;
    logic [31:0] st_addr, st_reg_value, st_addr_out, st_word0, st_word1;
    logic [3:0]  st_be0, st_be1;
    int          num_errors, tests_run, cyc;

    assign hready = hreadyout;
    ebr_top u_dut (.*);
    ebr_mem_model u_mem (.fetch_addr(fetch_addr), .ld_addr(ld_addr), .fetch_mem_word(fetch_mem_word),
                         .ld_cache_word0(ld_cache_word0), .ld_cache_word1(ld_cache_word1));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    function automatic logic [7:0] mb(input logic [31:0] x);
        mb = 8'h10 + {2'h0, x[5:0]};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task conclude;
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            num_errors++;
            $display("[ERR] %0t timeout", $time);
            conclude;
        end
    end

    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1; htrans <= ebr_pkg::HTRANS_NONSEQ; haddr <= a; hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
        chk(32'(hresp), 32'(ebr_pkg::HRESP_OKAY));
    endtask

    task automatic fe(input logic [31:0] a, input logic t, input logic e);
        fetch_req <= 1'b1; fetch_addr <= a; fetch_tlb_le <= t;
        @(posedge clk);
        fetch_req <= 1'b0;
        @(posedge clk);
        #1 chk(fill_word, e ? {mb(a + 3), mb(a + 2), mb(a + 1), mb(a)} : {mb(a), mb(a + 1), mb(a + 2), mb(a + 3)});
        chk(32'(fill_le), 32'(e));
    endtask

    task automatic ls(input logic [31:0] a, input logic [1:0] sz, input logic e, input logic rv);
        logic [31:0] x, w0, w1;
        logic [3:0]  b0, b1;
        logic [7:0]  by;
        int          n, p;
        n = (sz == 2'h0) ? 1 : (sz == 2'h1) ? 2 : 4;
        x = 32'h0; w0 = 32'h0; w1 = 32'h0; b0 = 4'h0; b1 = 4'h0;
        for (int k = 0; k < n; k++)
        begin
            x = (e ^ rv) ? x | ({24'h0, mb(a + k)} << (8 * k)) : {x[23:0], mb(a + k)};
            by = (e ^ rv) ? st_reg_value[8 * k +: 8] : st_reg_value[8 * (n - 1 - k) +: 8];
            p = int'(a[1:0]) + k;
            if (p < 4)
            begin
                w0[31 - 8 * p -: 8] = by; b0[3 - p] = 1'b1;
            end
            else
            begin
                w1[63 - 8 * p -: 8] = by; b1[7 - p] = 1'b1;
            end
        end
        ld_req <= 1'b1; ld_addr <= a; ld_size <= sz; ld_tlb_le <= e; ld_byte_rev <= rv;
        @(posedge clk);
        ld_req <= 1'b0;
        @(posedge clk);
        #1 chk(ld_result, x);
        chk(32'(ld_misaligned), 32'((sz == 2'h1 && a[0]) || (sz == 2'h2 && a[1:0] != 2'h0)));
        chk(32'(ld_le), 32'(e));
        st_req <= 1'b1; st_addr <= a; st_size <= sz; st_tlb_le <= e; st_byte_rev <= rv;
        @(posedge clk);
        st_req <= 1'b0;
        @(posedge clk);
        #1 chk({24'h0, st_be0, st_be1}, {24'h0, b0, b1});
        chk(st_word0 & {{8{b0[3]}}, {8{b0[2]}}, {8{b0[1]}}, {8{b0[0]}}}, w0);
        chk(st_word1 & {{8{b1[3]}}, {8{b1[2]}}, {8{b1[1]}}, {8{b1[0]}}}, w1);
        chk(st_addr_out, a);
        chk({30'h0, st_spans, st_misaligned},
            {30'h0, b1 != 4'h0, (sz == 2'h1 && a[0]) || (sz == 2'h2 && a[1:0] != 2'h0)});
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        {hsel, hwrite, htrans, haddr, hwdata, hsize} = '0;
        {fetch_req, fetch_tlb_le, fetch_addr, ld_req, ld_byte_rev, ld_tlb_le, ld_addr, ld_size} = '0;
        {st_req, st_byte_rev, st_tlb_le, st_addr, st_size} = '0;
        st_reg_value = 32'h1112_1314;
        rst_n = 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        hsize <= 3'h2;
        @(posedge clk);
        ahb(1'b0, 32'(ebr_pkg::ADDR_LE_REGION), 32'h0); chk(r, ebr_pkg::RST_LE_REGION);
        ahb(1'b0, 32'(ebr_pkg::ADDR_MACHINE), 32'h0); chk(r, ebr_pkg::RST_WORD);
        ahb(1'b1, 32'h0000_0020, 32'hFFFF_FFFF);
        ahb(1'b0, 32'h0000_0020, 32'h0); chk(r, 32'h0);
        ahb(1'b1, 32'(ebr_pkg::ADDR_LE_REGION), 32'h0000_0001);
        fe(32'h0000_0004, 1'b0, 1'b1);
        // New format needs a refetch before the words are trusted
        ahb(1'b1, 32'(ebr_pkg::ADDR_LE_REGION), 32'h0);
        fe(32'h0000_0004, 1'b1, 1'b0);
        ahb(1'b1, 32'(ebr_pkg::ADDR_MACHINE), 32'h0000_0003);
        fe(32'h0000_0008, 1'b1, 1'b1);
        fe(32'h0000_0008, 1'b0, 1'b0);
        // Two of the four fetches were little endian, one by region register and one by translation entry
        ahb(1'b0, 32'(ebr_pkg::ADDR_CNT_FETCH), 32'h0); chk(r, 32'h0000_0002);
        for (int s = 0; s < 3; s++)
            for (int m = 0; m < 4; m++)
            begin
                ls(32'h0000_0003, 2'(s), m[0], m[1]);
                ls(32'h0000_0008, 2'(s), m[0], m[1]);
            end
        conclude;
    end
endmodule
